// file: include/albd_pkg.sv
// shared constants and types for the alu and branch decoder
// Summary of operation
// - add-with-carry sums accumulator, carry and file byte into chosen destination
// - destination bit 0 writes accumulator, 1 writes back to file register
// - bank bit 0 uses fixed access bank, 1 uses bank select register
// - extended set, bank bit 0, address up to 95: indexed literal offset addressing
// - add-with-carry updates negative, wrap, carry, half-carry and zero flags
// - AND literal into accumulator, only negative and zero flags change
// - AND accumulator with file into destination, only negative and zero change
// - bit clear zeroes indexed bit 0..7, keeps others, touches no flags
// - taken branch loads incremented PC plus twice signed offset, flags untouched
// - taken branch uses two cycles, second idle; untaken is one cycle
// - upper byte 1110 0010 branches only when carry set
// - upper byte 1110 0110 branches only when negative set
// - upper byte 1110 0011 branches only when carry clear
// - upper byte 1110 0111 branches only when negative clear
// - modifying the program counter adds a second, idle instruction cycle
package albd_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int BANK_W = 4;
	localparam int PC_WIDTH = 21;
	localparam int FLAGS_W = 5;
	localparam int IDX_W = 3;
	localparam int INSTR_W = 16;

	// status flag positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_HALF = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_WRAP = 3;
	localparam int FLAG_NEG = 4;
	localparam logic [FLAGS_W-1:0] FLAGS_NZ_MASK = 5'h14;

	// reset values
	localparam logic [FLAGS_W-1:0] FLAGS_RESET = 5'h00;
	localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
	localparam logic [INSTR_W-1:0] INSTR_RESET = 16'h0000;

	// instruction word fields
	localparam int BIT_DEST = 9;
	localparam int BIT_BANK = 8;
	localparam int BIT_IDX_LSB = 9;

	// opcode patterns
	localparam logic [5:0] OPC_ADDC = 6'h08;
	localparam logic [5:0] OPC_ANDF = 6'h05;
	localparam logic [7:0] OPC_ANDL = 8'h0b;
	localparam logic [3:0] OPC_BCLR = 4'h9;
	localparam logic [7:0] OPC_BR_C = 8'he2;
	localparam logic [7:0] OPC_BR_N = 8'he6;
	localparam logic [7:0] OPC_BR_NC = 8'he3;
	localparam logic [7:0] OPC_BR_NN = 8'he7;

	// access bank split and indexed window
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [7:0] INDEX_LIMIT = 8'h5f;
	localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;

	// program counter step per instruction word, in bytes
	localparam int PC_STEP = 2;

	typedef enum logic [1:0] {Q_DECODE, Q_READ, Q_PROCESS, Q_WRITE} albd_phase_e;

	typedef enum logic [3:0] {
		OP_NONE, OP_ADDC, OP_ANDL, OP_ANDF, OP_BCLR,
		OP_BR_C, OP_BR_N, OP_BR_NC, OP_BR_NN
	} albd_op_e;

	typedef enum logic [1:0] {ALU_PASS, ALU_ADDC, ALU_AND, ALU_BCLR} albd_alu_e;
endpackage : albd_pkg

// file: include/albd_alu_if.sv
// carrier between the decoder and its arithmetic unit
`timescale 1ns/1ns
interface albd_alu_if;
	import albd_pkg::*;
	albd_alu_e op;
	logic [DATA_W-1:0] a;
	logic [DATA_W-1:0] b;
	logic [IDX_W-1:0] bit_idx;
	logic [FLAGS_W-1:0] flags_in;
	logic [DATA_W-1:0] result;
	logic [FLAGS_W-1:0] flags_out;

	modport client(output op, output a, output b, output bit_idx, output flags_in,
		input result, input flags_out);
	modport alu(input op, input a, input b, input bit_idx, input flags_in,
		output result, output flags_out);
endinterface : albd_alu_if

// file: core/albd_alu.sv
// arithmetic unit: add with carry, and, bit clear
`timescale 1ns/1ns
module albd_alu (
	// operands and results
	albd_alu_if.alu bus
);
	import albd_pkg::*;

	logic [DATA_W:0] sum;
	logic [4:0] low_sum;

	always_comb begin
		sum = {1'b0, bus.a} + {1'b0, bus.b} + {{DATA_W{1'b0}}, bus.flags_in[FLAG_CARRY]};
		low_sum = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.flags_in[FLAG_CARRY]};
		bus.result = bus.a;
		bus.flags_out = bus.flags_in;
		case (bus.op)
			ALU_ADDC: begin
				bus.result = sum[DATA_W-1:0];
				bus.flags_out[FLAG_CARRY] = sum[DATA_W];
				bus.flags_out[FLAG_HALF] = low_sum[4];
				bus.flags_out[FLAG_WRAP] = (bus.a[DATA_W-1] == bus.b[DATA_W-1])
					&& (sum[DATA_W-1] != bus.a[DATA_W-1]);
				bus.flags_out[FLAG_NEG] = sum[DATA_W-1];
				bus.flags_out[FLAG_ZERO] = (sum[DATA_W-1:0] == '0);
			end
			ALU_AND: begin
				bus.result = bus.a & bus.b;
				bus.flags_out[FLAG_NEG] = bus.result[DATA_W-1];
				bus.flags_out[FLAG_ZERO] = (bus.result == '0);
			end
			ALU_BCLR: begin
				bus.result = bus.b & ~(8'h01 << bus.bit_idx);
			end
			default: begin
				bus.result = bus.a;
			end
		endcase
	end
endmodule : albd_alu

// file: core/albd_decoder.sv
// decode and execute for add-with-carry, and, bit clear and flag branches
`timescale 1ns/1ns
module albd_decoder #(
	parameter int PC_W = albd_pkg::PC_WIDTH
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET,
	// instruction fetch
	input wire logic INSTR_VALID,
	input wire logic [albd_pkg::INSTR_W-1:0] INSTR_WORD,
	output logic INSTR_READY,
	// configuration
	input wire logic EXT_SET_ENABLE,
	input wire logic [albd_pkg::BANK_W-1:0] BANK_SELECT,
	input wire logic [albd_pkg::ADDR_W-1:0] INDEX_BASE,
	// data memory
	output logic [albd_pkg::ADDR_W-1:0] MEM_ADDR,
	output logic MEM_READ,
	input wire logic [albd_pkg::DATA_W-1:0] MEM_RDATA,
	output logic MEM_WRITE,
	output logic [albd_pkg::DATA_W-1:0] MEM_WDATA,
	// core state
	output logic [albd_pkg::DATA_W-1:0] ACC,
	output logic [albd_pkg::FLAGS_W-1:0] STATUS_FLAGS,
	output logic [PC_W-1:0] PROG_COUNTER,
	output logic BRANCH_TAKEN,
	output logic NOP_CYCLE
);
	import albd_pkg::*;

	albd_phase_e phase;
	albd_op_e op;
	logic [INSTR_W-1:0] instr;
	logic [DATA_W-1:0] result;
	logic [FLAGS_W-1:0] result_flags;
	logic accept;
	logic taken;
	logic [PC_W-1:0] next_pc;

	albd_alu_if alu_bus();

	albd_alu u_alu (
		.bus(alu_bus)
	);

	function automatic albd_op_e decode_op(input logic [INSTR_W-1:0] w);
		albd_op_e o;
		o = OP_NONE;
		if (w[15:8] == OPC_BR_C) o = OP_BR_C;
		else if (w[15:8] == OPC_BR_N) o = OP_BR_N;
		else if (w[15:8] == OPC_BR_NC) o = OP_BR_NC;
		else if (w[15:8] == OPC_BR_NN) o = OP_BR_NN;
		else if (w[15:8] == OPC_ANDL) o = OP_ANDL;
		else if (w[15:10] == OPC_ADDC) o = OP_ADDC;
		else if (w[15:10] == OPC_ANDF) o = OP_ANDF;
		else if (w[15:12] == OPC_BCLR) o = OP_BCLR;
		return o;
	endfunction : decode_op

	function automatic logic reads_file(input albd_op_e o);
		return (o == OP_ADDC) || (o == OP_ANDF) || (o == OP_BCLR);
	endfunction : reads_file

	function automatic logic is_branch(input albd_op_e o);
		return (o == OP_BR_C) || (o == OP_BR_N) || (o == OP_BR_NC) || (o == OP_BR_NN);
	endfunction : is_branch

	function automatic logic branch_cond(input albd_op_e o, input logic [FLAGS_W-1:0] f);
		logic c;
		c = 1'b0;
		case (o)
			OP_BR_C: c = f[FLAG_CARRY];
			OP_BR_N: c = f[FLAG_NEG];
			OP_BR_NC: c = !f[FLAG_CARRY];
			OP_BR_NN: c = !f[FLAG_NEG];
			default: c = 1'b0;
		endcase
		return c;
	endfunction : branch_cond

	function automatic logic writes_file(input albd_op_e o, input logic [INSTR_W-1:0] w);
		return (o == OP_BCLR) || (((o == OP_ADDC) || (o == OP_ANDF)) && w[BIT_DEST]);
	endfunction : writes_file

	function automatic logic writes_acc(input albd_op_e o, input logic [INSTR_W-1:0] w);
		return (o == OP_ANDL) || (((o == OP_ADDC) || (o == OP_ANDF)) && !w[BIT_DEST]);
	endfunction : writes_acc

	function automatic logic [ADDR_W-1:0] resolve_addr(input logic bank_mode,
			input logic [7:0] f, input logic ext, input logic [BANK_W-1:0] bsel,
			input logic [ADDR_W-1:0] base);
		logic [ADDR_W-1:0] a;
		if (bank_mode) a = {bsel, f};
		else if (ext && (f <= INDEX_LIMIT)) a = base + {4'h0, f};
		else if (f < ACCESS_SPLIT) a = {ACCESS_LOW_BANK, f};
		else a = {ACCESS_HIGH_BANK, f};
		return a;
	endfunction : resolve_addr

	function automatic logic [PC_W-1:0] branch_offset(input logic [7:0] n);
		return {{(PC_W-9){n[7]}}, n, 1'b0};
	endfunction : branch_offset

	// fetch is only taken at the decode phase of a live cycle
	// idle cycle refuses fetch
	assign INSTR_READY = (phase == Q_DECODE) && !NOP_CYCLE;
	assign accept = INSTR_VALID && INSTR_READY;
	assign MEM_READ = (phase == Q_READ) && reads_file(op);
	assign MEM_WRITE = (phase == Q_WRITE) && writes_file(op, instr);
	assign taken = is_branch(op) && branch_cond(op, STATUS_FLAGS);
	assign BRANCH_TAKEN = (phase == Q_WRITE) && taken;
	assign next_pc = PROG_COUNTER + branch_offset(instr[7:0]);

	assign alu_bus.op = (op == OP_ADDC) ? ALU_ADDC :
		((op == OP_ANDL) || (op == OP_ANDF)) ? ALU_AND :
		(op == OP_BCLR) ? ALU_BCLR : ALU_PASS;
	assign alu_bus.a = ACC;
	assign alu_bus.b = (op == OP_ANDL) ? instr[7:0] : MEM_RDATA;
	assign alu_bus.bit_idx = instr[BIT_IDX_LSB +: IDX_W];
	assign alu_bus.flags_in = STATUS_FLAGS;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			phase <= Q_DECODE;
		end else begin
			case (phase)
				Q_DECODE: phase <= Q_READ;
				Q_READ: phase <= Q_PROCESS;
				Q_PROCESS: phase <= Q_WRITE;
				Q_WRITE: phase <= Q_DECODE;
				default: phase <= Q_DECODE;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			op <= OP_NONE;
			instr <= INSTR_RESET;
		end else if (phase == Q_DECODE) begin
			op <= accept ? decode_op(INSTR_WORD) : OP_NONE;
			if (accept) begin
				instr <= INSTR_WORD;
			end
		end
	end

	// address is fixed at decode so a late bank change cannot split a read from its write
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			MEM_ADDR <= ADDR_RESET;
		end else if (accept) begin
			MEM_ADDR <= resolve_addr(INSTR_WORD[BIT_BANK], INSTR_WORD[7:0],
				EXT_SET_ENABLE, BANK_SELECT, INDEX_BASE);
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			result <= ACC_RESET;
			result_flags <= FLAGS_RESET;
		end else if (phase == Q_PROCESS) begin
			result <= alu_bus.result;
			result_flags <= alu_bus.flags_out;
		end
	end

	assign MEM_WDATA = result;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ACC <= ACC_RESET;
		end else if ((phase == Q_WRITE) && writes_acc(op, instr)) begin
			ACC <= result;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			STATUS_FLAGS <= FLAGS_RESET;
		end else if ((phase == Q_WRITE)
				&& ((op == OP_ADDC) || (op == OP_ANDL) || (op == OP_ANDF))) begin
			STATUS_FLAGS <= result_flags;
		end
	end

	// increment at fetch, offset at write
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			PROG_COUNTER <= '0;
		end else if (accept) begin
			PROG_COUNTER <= PROG_COUNTER + PC_W'(PC_STEP);
		end else if (BRANCH_TAKEN) begin
			PROG_COUNTER <= next_pc;
		end
	end

	// idle cycle after a pc write
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			NOP_CYCLE <= 1'b0;
		end else if (phase == Q_WRITE) begin
			NOP_CYCLE <= BRANCH_TAKEN;
		end
	end

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RESET);

	sequence s_phases;
		phase == Q_READ ##1 phase == Q_PROCESS ##1 phase == Q_WRITE ##1 phase == Q_DECODE;
	endsequence

	sequence s_idle_cycle;
		(NOP_CYCLE && !MEM_READ && !MEM_WRITE && !INSTR_READY && !BRANCH_TAKEN) [*4];
	endsequence

	property p_phase_order;
		phase == Q_DECODE |=> s_phases;
	endproperty
	a_phase_order: assert property (p_phase_order)
		else $error("instruction phases out of order");

	property p_taken_idle;
		BRANCH_TAKEN |=> s_idle_cycle ##1 !NOP_CYCLE;
	endproperty
	a_taken_idle: assert property (p_taken_idle)
		else $error("taken branch not followed by exactly one idle cycle");

	property p_taken_target;
		BRANCH_TAKEN |=> PROG_COUNTER == $past(PROG_COUNTER) + branch_offset($past(instr[7:0]));
	endproperty
	a_taken_target: assert property (p_taken_target)
		else $error("branch target wrong");

	property p_untaken;
		(phase == Q_WRITE) && is_branch(op) && !taken |=> $stable(PROG_COUNTER) && !NOP_CYCLE;
	endproperty
	a_untaken: assert property (p_untaken)
		else $error("untaken branch changed pc or stalled");

	property p_carry_set;
		(phase == Q_WRITE) && (op == OP_BR_C) |-> BRANCH_TAKEN == STATUS_FLAGS[FLAG_CARRY];
	endproperty
	a_carry_set: assert property (p_carry_set)
		else $error("carry-set branch decision wrong");

	property p_neg_clear;
		(phase == Q_WRITE) && (op == OP_BR_NN) |-> BRANCH_TAKEN == !STATUS_FLAGS[FLAG_NEG];
	endproperty
	a_neg_clear: assert property (p_neg_clear)
		else $error("negative-clear branch decision wrong");

	property p_neg_set;
		(phase == Q_WRITE) && (op == OP_BR_N) |-> BRANCH_TAKEN == STATUS_FLAGS[FLAG_NEG];
	endproperty
	a_neg_set: assert property (p_neg_set)
		else $error("negative-set branch decision wrong");

	property p_carry_clear;
		(phase == Q_WRITE) && (op == OP_BR_NC) |-> BRANCH_TAKEN == !STATUS_FLAGS[FLAG_CARRY];
	endproperty
	a_carry_clear: assert property (p_carry_clear)
		else $error("carry-clear branch decision wrong");

	property p_bank_addr;
		accept && INSTR_WORD[BIT_BANK] |=>
			MEM_ADDR == {$past(BANK_SELECT), $past(INSTR_WORD[7:0])};
	endproperty
	a_bank_addr: assert property (p_bank_addr)
		else $error("bank selected address wrong");

	property p_indexed;
		accept && !INSTR_WORD[BIT_BANK] && EXT_SET_ENABLE && (INSTR_WORD[7:0] <= INDEX_LIMIT)
			|=> MEM_ADDR == ADDR_W'($past(INDEX_BASE) + $past(INSTR_WORD[7:0]));
	endproperty
	a_indexed: assert property (p_indexed)
		else $error("indexed address wrong");

	property p_addc_acc;
		(phase == Q_PROCESS) && (op == OP_ADDC) && !instr[BIT_DEST] ##1 1'b1 |=>
			ACC == DATA_W'($past(ACC, 2) + $past(MEM_RDATA, 2)
				+ DATA_W'($past(STATUS_FLAGS[FLAG_CARRY], 2)));
	endproperty
	a_addc_acc: assert property (p_addc_acc)
		else $error("add with carry result wrong");

	property p_file_dest;
		MEM_WRITE |-> ((op == OP_BCLR) || instr[BIT_DEST]) ##1 $stable(ACC);
	endproperty
	a_file_dest: assert property (p_file_dest)
		else $error("file write with accumulator destination");

	property p_clear_bit;
		(phase == Q_PROCESS) && (op == OP_BCLR) |=>
			MEM_WRITE && (MEM_WDATA == ($past(MEM_RDATA) & ~(8'h01 << $past(alu_bus.bit_idx))))
			##1 $stable(STATUS_FLAGS);
	endproperty
	a_clear_bit: assert property (p_clear_bit)
		else $error("bit clear wrong or flags changed");

	property p_and_literal;
		(phase == Q_WRITE) && (op == OP_ANDL) |=> (ACC == ($past(ACC) & $past(instr[7:0])))
			&& ((STATUS_FLAGS & ~FLAGS_NZ_MASK) == ($past(STATUS_FLAGS) & ~FLAGS_NZ_MASK));
	endproperty
	a_and_literal: assert property (p_and_literal)
		else $error("and literal result or flags wrong");

	property p_and_file;
		(phase == Q_WRITE) && (op == OP_ANDF) |=>
			((STATUS_FLAGS & ~FLAGS_NZ_MASK) == ($past(STATUS_FLAGS) & ~FLAGS_NZ_MASK));
	endproperty
	a_and_file: assert property (p_and_file)
		else $error("and with file changed flags other than negative and zero");
endmodule : albd_decoder

// file: testbench/albd_decoder_bench.sv
// self-checking bench for the alu and branch decoder
`timescale 1ns/1ns
module albd_decoder_bench;
	import albd_pkg::*;
	logic CLOCK = 1'b0;
	logic RESET = 1'b1;
	logic INSTR_VALID = 1'b0;
	logic [INSTR_W-1:0] INSTR_WORD = 16'h0000;
	logic INSTR_READY;
	logic EXT_SET_ENABLE = 1'b0;
	logic [BANK_W-1:0] BANK_SELECT = 4'h0;
	logic [ADDR_W-1:0] INDEX_BASE = 12'h000;
	logic [ADDR_W-1:0] MEM_ADDR;
	logic MEM_READ;
	logic MEM_WRITE;
	logic BRANCH_TAKEN;
	logic NOP_CYCLE;
	logic [DATA_W-1:0] MEM_RDATA;
	logic [DATA_W-1:0] MEM_WDATA;
	logic [DATA_W-1:0] ACC;
	logic [FLAGS_W-1:0] STATUS_FLAGS;
	logic [PC_WIDTH-1:0] PROG_COUNTER;
	logic [DATA_W-1:0] mem [0:4095];
	logic [31:0] seed = 32'he7df;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [DATA_W-1:0] e_acc = ACC_RESET;
	logic [FLAGS_W-1:0] e_flags = FLAGS_RESET;
	logic [PC_WIDTH-1:0] e_pc = '0;
	// boundary offsets, bit indices and the indexed window edge
	logic [15:0] corner [18] = '{16'h0b00, 16'h0bff, 16'h225f, 16'h2060, 16'h21aa, 16'h1733,
		16'h1410, 16'h9e05, 16'h9105, 16'he280, 16'he37f, 16'he680, 16'he77f, 16'he200,
		16'he300, 16'he600, 16'he700, 16'hf000};

	// memory answers in the process phase from the held address
	assign MEM_RDATA = mem[MEM_ADDR];

	albd_decoder #(.PC_W(PC_WIDTH)) dut (
		.CLOCK(CLOCK), .RESET(RESET), .INSTR_VALID(INSTR_VALID), .INSTR_WORD(INSTR_WORD),
		.INSTR_READY(INSTR_READY), .EXT_SET_ENABLE(EXT_SET_ENABLE), .BANK_SELECT(BANK_SELECT),
		.INDEX_BASE(INDEX_BASE), .MEM_ADDR(MEM_ADDR), .MEM_READ(MEM_READ),
		.MEM_RDATA(MEM_RDATA), .MEM_WRITE(MEM_WRITE), .MEM_WDATA(MEM_WDATA), .ACC(ACC),
		.STATUS_FLAGS(STATUS_FLAGS), .PROG_COUNTER(PROG_COUNTER),
		.BRANCH_TAKEN(BRANCH_TAKEN), .NOP_CYCLE(NOP_CYCLE)
	);

	initial begin
		forever #5 CLOCK = ~CLOCK;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [ADDR_W-1:0] eff_addr(input logic [15:0] w);
		if (w[BIT_BANK])
			return {BANK_SELECT, w[7:0]};
		if (EXT_SET_ENABLE && w[7:0] <= 8'h5f)
			return INDEX_BASE + {4'h0, w[7:0]};
		return {(w[7:0] < 8'h60) ? 4'h0 : 4'hf, w[7:0]};
	endfunction : eff_addr

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("errors %0d checks_done %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic run_instr(input logic [15:0] w);
		logic [31:0] r;
		logic [7:0] m;
		logic [7:0] res;
		logic [8:0] sum;
		logic [4:0] low;
		logic file_op;
		logic wr_file;
		logic wr_acc;
		logic taken;
		logic c;
		logic n;
		logic [ADDR_W-1:0] ea;
		logic [PC_WIDTH-1:0] pc1;
		int k;
		r = rnd();
		EXT_SET_ENABLE = r[0];
		BANK_SELECT = r[7:4];
		INDEX_BASE = r[19:8];
		k = 0;
		while (INSTR_READY !== 1'b1 && k < 20) begin
			@(negedge CLOCK);
			k++;
		end
		INSTR_VALID = 1'b1;
		INSTR_WORD = w;
		ea = eff_addr(w);
		m = mem[ea];
		c = e_flags[FLAG_CARRY];
		n = e_flags[FLAG_NEG];
		res = e_acc;
		file_op = 1'b0;
		wr_file = 1'b0;
		wr_acc = 1'b0;
		taken = (w[15:8] == OPC_BR_C && c) || (w[15:8] == OPC_BR_N && n)
			|| (w[15:8] == OPC_BR_NC && !c) || (w[15:8] == OPC_BR_NN && !n);
		if (w[15:10] == OPC_ADDC) begin
			file_op = 1'b1;
			sum = {1'b0, e_acc} + {1'b0, m} + {8'h00, c};
			low = {1'b0, e_acc[3:0]} + {1'b0, m[3:0]} + {4'h0, c};
			res = sum[7:0];
			e_flags[FLAG_CARRY] = sum[8];
			e_flags[FLAG_HALF] = low[4];
			e_flags[FLAG_WRAP] = (e_acc[7] == m[7]) && (res[7] != e_acc[7]);
		end else if (w[15:10] == OPC_ANDF) begin
			file_op = 1'b1;
			res = e_acc & m;
		end else if (w[15:8] == OPC_ANDL) begin
			res = e_acc & w[7:0];
		end else if (w[15:12] == OPC_BCLR) begin
			file_op = 1'b1;
			res = m & ~(8'h01 << w[11:9]);
		end
		if (w[15:10] == OPC_ADDC || w[15:10] == OPC_ANDF || w[15:8] == OPC_ANDL) begin
			e_flags[FLAG_NEG] = res[7];
			e_flags[FLAG_ZERO] = (res == 8'h00);
			wr_file = w[BIT_DEST];
			wr_acc = !w[BIT_DEST];
			if (w[15:8] == OPC_ANDL)
				wr_acc = 1'b1;
			if (w[15:8] == OPC_ANDL)
				wr_file = 1'b0;
		end
		if (w[15:12] == OPC_BCLR)
			wr_file = 1'b1;
		@(negedge CLOCK);
		INSTR_VALID = 1'b0;
		// config moves after accept; the held address must not follow it
		EXT_SET_ENABLE = !EXT_SET_ENABLE;
		BANK_SELECT = ~BANK_SELECT;
		INDEX_BASE = ~INDEX_BASE;
		pc1 = e_pc + 21'd2;
		check("pc_step", PROG_COUNTER, pc1);
		check("mem_read", MEM_READ, file_op);
		if (file_op)
			check("mem_addr", MEM_ADDR, ea);
		repeat (2) @(negedge CLOCK);
		check("mem_write", MEM_WRITE, wr_file);
		if (wr_file) begin
			check("mem_wdata", MEM_WDATA, res);
			mem[ea] = res;
		end
		check("branch_taken", BRANCH_TAKEN, taken);
		@(negedge CLOCK);
		if (wr_acc)
			e_acc = res;
		e_pc = taken ? pc1 + {{(PC_WIDTH-9){w[7]}}, w[7:0], 1'b0} : pc1;
		check("acc", ACC, e_acc);
		check("flags", STATUS_FLAGS, e_flags);
		check("pc", PROG_COUNTER, e_pc);
		check("nop_cycle", NOP_CYCLE, taken);
		check("ready_next", INSTR_READY, !taken);
		if (taken) begin
			repeat (3) @(negedge CLOCK);
			check("nop_hold", NOP_CYCLE, 1'b1);
			@(negedge CLOCK);
			check("nop_end", NOP_CYCLE, 1'b0);
			check("ready_after_nop", INSTR_READY, 1'b1);
		end
	endtask : run_instr

	// hang guard, well above 418 instructions (18 corner, 400 random) of at most 8 clocks
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			complete_run();
		end
	end

	initial begin
		logic [31:0] r;
		logic [15:0] w;
		for (int i = 0; i < 4096; i++) begin
			r = rnd();
			mem[i] = r[7:0];
		end
		repeat (5) @(negedge CLOCK);
		RESET = 1'b0;
		@(negedge CLOCK);
		check("acc_reset", ACC, ACC_RESET);
		check("pc_reset", PROG_COUNTER, 21'h00_0000);
		foreach (corner[i])
			run_instr(corner[i]);
		for (int i = 0; i < 400; i++) begin
			r = rnd();
			w = r[15:0];
			case (r[19:16])
				4'h1: w[15:10] = OPC_ANDF;
				4'h2: w[15:8] = OPC_ANDL;
				4'h3: w[15:12] = OPC_BCLR;
				4'h4: w[15:8] = OPC_BR_C;
				4'h5: w[15:8] = OPC_BR_N;
				4'h6: w[15:8] = OPC_BR_NC;
				4'h7: w[15:8] = OPC_BR_NN;
				default: w[15:10] = OPC_ADDC;
			endcase
			run_instr(w);
		end
		complete_run();
	end
endmodule : albd_decoder_bench
